// File: shared/rtcca_defs.vh
/*
  register offsets, field positions, reset values and timing counts
  for the calendar alarm control block; included by rtl/rtcca_top.v
*/
`ifndef RTCCA_DEFS_VH
`define RTCCA_DEFS_VH

`define RTCCA_OFS_CTRL 12'h000
`define RTCCA_OFS_BUSY 12'h004
`define RTCCA_OFS_DEBUG 12'h008
`define RTCCA_OFS_IRQ_STATUS 12'h00C
`define RTCCA_OFS_IRQ_MASK 12'h010
`define RTCCA_OFS_CLOCK 12'h018
`define RTCCA_OFS_ALARM_MASK 12'h01C
`define RTCCA_OFS_ALARM 12'h020

`define RTCCA_CTRL_RST 16'h0000
`define RTCCA_ALARM_RST 32'h0000_0000

`define RTCCA_BIT_SOFT_RESET 0
`define RTCCA_BIT_ENABLE 1
`define RTCCA_MODE_LSB 2
`define RTCCA_BIT_HOUR_FMT 6
`define RTCCA_BIT_CLR_MATCH 7

`define RTCCA_MODE_WIDE 2'h0
`define RTCCA_MODE_NARROW 2'h1
`define RTCCA_MODE_CAL 2'h2

`define RTCCA_BUSY_SOFT_RESET 0
`define RTCCA_BUSY_ENABLE 1
`define RTCCA_BUSY_ALARM 2

`define RTCCA_IRQ_ALARM 0

`define RTCCA_SEC_LSB 0
`define RTCCA_MIN_LSB 6
`define RTCCA_HOUR_LSB 12
`define RTCCA_DAY_LSB 17
`define RTCCA_MON_LSB 22
`define RTCCA_YEAR_LSB 26

`define RTCCA_SYNC_STAGES 2
`define RTCCA_DEPTH_YEAR 3'h6

`endif

// File: rtl/rtcca_top.v
/*
  calendar alarm control of a real-time counter: control register,
  busy flags, alarm compare, sticky interrupt, ahb-lite slave.
  assumes counter_source_clock is asynchronous to hclk; the clock
  value arrives from the counter core on that clock.
*/
// The AHB-Lite slave port is this design's own decision.
// Notes on behaviour
// (RULE1) clear_on_match bit 7 clears counter on alarm 0 in wide/cal modes; here match needs calendar mode, so wide never clears.
// (RULE2) clear_on_match and hour format writable only while disabled.
// (RULE3) bit 6 picks 24-hour (0) or 12-hour am/pm (1) in calendar mode.
// (RULE4) mode bits 3:2: 0 wide, 1 narrow, 2 calendar, 3 reserved.
// (RULE5) enable reads back at once; busy flag until synchronised.
// (RULE6) soft reset 1 resets all but debug control and disables.
// (RULE7) soft reset write discards other fields of that write.
// (RULE8) soft reset bit reads 1 until reset completes, then clears.
// (RULE9) calendar mode compares alarm and clock under mask depth.
// (RULE10) alarm flag sets one counter cycle after the match; here the toggle then crosses 2 hclk sync stages.
// (RULE11) alarm fields: year 31:26 month 25:22 day 21:17 hour 16:12 etc.
// (RULE12) fields compare when mask depth is high enough; year only at 6.
// (RULE13) alarm at 0x20 is write-synchronised and write-protectable.
// (RULE14) alarm flag sticky until software writes one to it.
`include "rtcca_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rtcca_top #(
  parameter SYNC_STAGES = `RTCCA_SYNC_STAGES
) (
  // bus side
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // counter side
  input wire counter_source_clock,
  input wire [31:0] clock_value,
  input wire write_protect,
  output reg counter_enable,
  output reg counter_clear,
  output reg [1:0] counter_mode,
  output reg hour_format_select,
  output reg debug_control,
  // interrupt
  output wire irq
);

  ////////////////////////////////////////////////////////////////////
  function [31:0] rtcca_field_mask;
    input [2:0] depth;
    begin
      rtcca_field_mask = 32'h0000_0000;
      if (depth > 3'h0) rtcca_field_mask[5:0] = 6'h3F; // RULE12
      if (depth > 3'h1) rtcca_field_mask[11:6] = 6'h3F;
      if (depth > 3'h2) rtcca_field_mask[16:12] = 5'h1F;
      if (depth > 3'h3) rtcca_field_mask[21:17] = 5'h1F;
      if (depth > 3'h4) rtcca_field_mask[25:22] = 4'hF;
      if (depth == `RTCCA_DEPTH_YEAR) rtcca_field_mask[31:26] = 6'h3F;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus side registers
  reg ap_valid_r;
  reg ap_write_r;
  reg [11:0] ap_addr_r;
  reg enable_r;
  reg clr_match_r;
  reg hour_fmt_r;
  reg [1:0] mode_r;
  reg [2:0] mask_depth_r;
  reg [31:0] alarm_r;
  reg irq_status_r;
  reg irq_mask_r;
  reg soft_busy_r;
  reg en_busy_r;
  reg alarm_busy_r;
  reg en_req_t_r;
  reg rst_req_t_r;
  reg alm_req_t_r;
  reg [SYNC_STAGES-1:0] ack_sync_r;
  reg [SYNC_STAGES-1:0] match_sync_r;
  reg match_seen_r;
  reg [31:0] clock_hold_r;
  reg match_d_seen;
  reg [1:0] snap_sync_r;
  reg snap_seen_r;

  // counter side registers
  reg snap_t_r;
  reg [31:0] snap_r;
  reg [1:0] snap_ack_r;
  reg [2:0] req_seen_r;
  reg ack_t_r;
  reg match_t_r;
  reg [31:0] alarm_cnt_r;
  reg [2:0] depth_cnt_r;
  reg match_d_r;

  wire take = hsel & hready & htrans[1];
  wire wr = ap_valid_r & ap_write_r;
  wire wr_ctrl = wr & (ap_addr_r == `RTCCA_OFS_CTRL);
  // one data-phase strobe per writable register
  wire wr_alarm = wr & (ap_addr_r == `RTCCA_OFS_ALARM);
  wire wr_amask = wr & (ap_addr_r == `RTCCA_OFS_ALARM_MASK);
  wire wr_imask = wr & (ap_addr_r == `RTCCA_OFS_IRQ_MASK);
  wire wr_istat = wr & (ap_addr_r == `RTCCA_OFS_IRQ_STATUS);
  wire wr_debug = wr & (ap_addr_r == `RTCCA_OFS_DEBUG);
  wire soft_req = wr_ctrl & hwdata[`RTCCA_BIT_SOFT_RESET];
  wire ack_edge = ack_sync_r[SYNC_STAGES-1] ^ match_seen_r;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_status_r & irq_mask_r;

  ////////////////////////////////////////////////////////////////////
  // address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 12'h000;
    end else begin
      ap_valid_r <= take;
      ap_write_r <= hwrite;
      ap_addr_r <= haddr;
    end
  end

  // read mux is registered at address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      case (haddr)
        `RTCCA_OFS_CTRL:
          hrdata <= {24'h00_0000, clr_match_r, hour_fmt_r, 2'b00,
                     mode_r, enable_r, soft_busy_r}; // RULE8
        `RTCCA_OFS_BUSY:
          hrdata <= {29'h0000_0000, alarm_busy_r, en_busy_r, soft_busy_r};
        `RTCCA_OFS_DEBUG: hrdata <= {31'h0000_0000, debug_control};
        `RTCCA_OFS_IRQ_STATUS: hrdata <= {31'h0000_0000, irq_status_r};
        `RTCCA_OFS_IRQ_MASK: hrdata <= {31'h0000_0000, irq_mask_r};
        `RTCCA_OFS_CLOCK: hrdata <= clock_hold_r;
        `RTCCA_OFS_ALARM_MASK: hrdata <= {29'h0000_0000, mask_depth_r};
        `RTCCA_OFS_ALARM: hrdata <= alarm_r;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control and alarm registers; soft reset leaves debug_control alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= 1'b0;
      clr_match_r <= 1'b0;
      hour_fmt_r <= 1'b0;
      mode_r <= `RTCCA_MODE_WIDE;
      mask_depth_r <= 3'h0;
      alarm_r <= `RTCCA_ALARM_RST;
      irq_mask_r <= 1'b0;
      debug_control <= 1'b0;
      soft_busy_r <= 1'b0;
      en_busy_r <= 1'b0;
      alarm_busy_r <= 1'b0;
      en_req_t_r <= 1'b0;
      rst_req_t_r <= 1'b0;
      alm_req_t_r <= 1'b0;
    end else begin
      if (soft_req & ~soft_busy_r) begin
        soft_busy_r <= 1'b1; // RULE7
        rst_req_t_r <= ~rst_req_t_r;
        // fields drop at once so the counter side never reloads them
        enable_r <= 1'b0; // RULE6
        clr_match_r <= 1'b0;
        hour_fmt_r <= 1'b0;
        mode_r <= `RTCCA_MODE_WIDE;
        mask_depth_r <= 3'h0;
        alarm_r <= `RTCCA_ALARM_RST;
        irq_mask_r <= 1'b0;
        en_busy_r <= 1'b0;
        alarm_busy_r <= 1'b0;
      end else if (soft_busy_r & ack_edge) begin
        soft_busy_r <= 1'b0; // RULE8
      end else if (!soft_busy_r) begin
        // clear first: a write in the same cycle keeps its busy flag
        if (ack_edge) begin
          en_busy_r <= 1'b0;
          alarm_busy_r <= 1'b0;
        end
        if (wr_ctrl) begin
          if (!enable_r) begin
            clr_match_r <= hwdata[`RTCCA_BIT_CLR_MATCH]; // RULE2
            hour_fmt_r <= hwdata[`RTCCA_BIT_HOUR_FMT];
            mode_r <= hwdata[`RTCCA_MODE_LSB+1:`RTCCA_MODE_LSB];
          end
          if (hwdata[`RTCCA_BIT_ENABLE] != enable_r) begin
            enable_r <= hwdata[`RTCCA_BIT_ENABLE]; // RULE5
            en_busy_r <= 1'b1;
            en_req_t_r <= ~en_req_t_r;
          end
        end
        if (wr_alarm & ~write_protect) begin
          alarm_r <= hwdata; // RULE13
          alarm_busy_r <= 1'b1;
          alm_req_t_r <= ~alm_req_t_r;
        end
        if (wr_amask) begin
          mask_depth_r <= hwdata[2:0]; // RULE12
          alarm_busy_r <= 1'b1;
          alm_req_t_r <= ~alm_req_t_r;
        end
        if (wr_imask)
          irq_mask_r <= hwdata[`RTCCA_IRQ_ALARM];
      end
      if (wr_debug)
        debug_control <= hwdata[0];
    end
  end

  // sticky alarm flag: set beats clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= 1'b0;
    end else if (match_sync_r[SYNC_STAGES-1] ^ match_d_seen) begin
      irq_status_r <= 1'b1; // RULE10
    end else if (wr_istat & hwdata[`RTCCA_IRQ_ALARM]) begin
      irq_status_r <= 1'b0; // RULE14
    end else if (soft_busy_r & ack_edge) begin
      irq_status_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // handshake return into hclk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_sync_r <= {SYNC_STAGES{1'b0}};
      match_sync_r <= {SYNC_STAGES{1'b0}};
      match_seen_r <= 1'b0;
      match_d_seen <= 1'b0;
    end else begin
      ack_sync_r <= {ack_sync_r[SYNC_STAGES-2:0], ack_t_r};
      match_sync_r <= {match_sync_r[SYNC_STAGES-2:0], match_t_r};
      match_seen_r <= ack_sync_r[SYNC_STAGES-1];
      match_d_seen <= match_sync_r[SYNC_STAGES-1];
    end
  end

  // clock snapshot receive: the word is stable while its toggle is new,
  // so the whole word is copied without sampling a moving bus
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_sync_r <= 2'b00;
      snap_seen_r <= 1'b0;
      clock_hold_r <= 32'h0000_0000;
    end else begin
      snap_sync_r <= {snap_sync_r[0], snap_t_r};
      snap_seen_r <= snap_sync_r[1];
      if (snap_sync_r[1] ^ snap_seen_r)
        clock_hold_r <= snap_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter clock domain; control words are stable while a request
  // toggle is in flight, so they are taken on the synchronised toggle
  wire [2:0] req_now = {alm_req_t_r, rst_req_t_r, en_req_t_r};
  reg [2:0] req_s1_r;
  reg [2:0] req_s2_r;
  wire req_any = |(req_s2_r ^ req_seen_r);
  wire cal_mode = (counter_mode == `RTCCA_MODE_CAL);
  wire match_now = cal_mode & counter_enable &
    (((alarm_cnt_r ^ clock_value) & rtcca_field_mask(depth_cnt_r))
      == 32'h0000_0000); // RULE9 RULE11

  always @(posedge counter_source_clock or negedge hresetn) begin
    if (!hresetn) begin
      req_s1_r <= 3'b000;
      req_s2_r <= 3'b000;
      req_seen_r <= 3'b000;
      ack_t_r <= 1'b0;
      match_t_r <= 1'b0;
      match_d_r <= 1'b0;
      alarm_cnt_r <= `RTCCA_ALARM_RST;
      depth_cnt_r <= 3'h0;
      counter_enable <= 1'b0;
      counter_clear <= 1'b0;
      counter_mode <= `RTCCA_MODE_WIDE;
      hour_format_select <= 1'b0;
    end else begin
      req_s1_r <= req_now;
      req_s2_r <= req_s1_r;
      req_seen_r <= req_s2_r;
      match_d_r <= match_now;
      if (req_any) begin
        ack_t_r <= ~ack_t_r;
        counter_enable <= enable_r; // RULE5
        alarm_cnt_r <= alarm_r;
        depth_cnt_r <= mask_depth_r;
        counter_mode <= mode_r; // RULE4
        hour_format_select <= hour_fmt_r; // RULE3
        if (req_s2_r[1] ^ req_seen_r[1]) begin
          counter_enable <= 1'b0; // RULE6
          counter_mode <= `RTCCA_MODE_WIDE;
          hour_format_select <= 1'b0;
          alarm_cnt_r <= `RTCCA_ALARM_RST;
          depth_cnt_r <= 3'h0;
        end
      end else if (~counter_enable) begin
        counter_mode <= mode_r;
        hour_format_select <= hour_fmt_r;
      end
      if (match_now & ~match_d_r)
        match_t_r <= ~match_t_r; // RULE10
      counter_clear <= match_now & clr_match_r &
        (counter_mode != `RTCCA_MODE_NARROW) &
        (counter_mode != 2'h3); // RULE1
    end
  end

  // clock snapshot send: a new word only once the last one was taken;
  // the read value lags the counter by a few cycles of both clocks
  always @(posedge counter_source_clock or negedge hresetn) begin
    if (!hresetn) begin
      snap_ack_r <= 2'b00;
      snap_t_r <= 1'b0;
      snap_r <= 32'h0000_0000;
    end else begin
      snap_ack_r <= {snap_ack_r[0], snap_seen_r};
      if (snap_ack_r[1] == snap_t_r) begin
        snap_r <= clock_value;
        snap_t_r <= ~snap_t_r;
      end
    end
  end

endmodule // rtcca_top

`default_nettype wire

// File: tb/rtcca_chk.sv
/* port assertions for rtcca_top, all sampled on hclk
   bound to rtcca_top at the foot of this file */
`timescale 1ns/1ps
`default_nettype none
module rtcca_chk (
  // bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // counter side and interrupt
  input wire logic counter_enable,
  input wire logic counter_clear,
  input wire logic [1:0] counter_mode,
  input wire logic irq
);
  logic wr_r;
  logic [11:0] adr_r;
  logic [7:0] since_r;
  wire logic take = hsel && hready && htrans[1];
  wire logic ctl_wr = wr_r && adr_r == 12'h000;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since the last control write, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      adr_r <= 12'h000;
      since_r <= 8'hff;
    end else begin
      wr_r <= take && hwrite;
      adr_r <= haddr;
      if (ctl_wr) since_r <= 8'h00;
      else if (since_r != 8'hff) since_r <= since_r + 8'h01;
    end
  end
  a_unmapped_zero: assert property (take && !hwrite
    && haddr > 12'h020 |=> hrdata == 32'h0000_0000) else $error("unmapped");
  a_mask_drop_irq: assert property (wr_r && adr_r == 12'h010
    && !hwdata[0] |=> !irq) else $error("irq while masked");
  a_enable_arrives: assert property (
    ctl_wr && hwdata[1:0] == 2'b10 |-> ##[1:60] counter_enable)
    else $error("enable late");
  a_soft_reset_request_disables: assert property (
    ctl_wr && hwdata[0] |-> ##[1:60] !counter_enable)
    else $error("still enabled");
  a_enable_cause: assert property (
    $rose(counter_enable) |-> since_r < 8'h64) else $error("stray enable");
  a_mode_cause: assert property (
    $changed(counter_mode) |-> since_r < 8'h64) else $error("stray mode");
  a_clear_mode: assert property (
    counter_clear |-> counter_mode != 2'h1) else $error("clear in mode 1");
  a_irq_sticky: assert property (irq && !(wr_r && adr_r inside
    {12'h000, 12'h00c, 12'h010}) |=> irq) else $error("irq dropped");
endmodule // rtcca_chk
bind rtcca_top rtcca_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .counter_enable, .counter_clear,
  .counter_mode, .irq);
`default_nettype wire

// File: tb/tb_rtcca_top.sv
/* self-checking bench for rtcca_top
   drives ahb-lite, the counter clock and the clock value */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("wrong value %0t %h %h", $time, a, e); end end
module tb_rtcca_top;
  logic hclk = 1'b0, cclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic hwrite = 1'b0, wprot = 1'b0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, cval = '0, q, rd_q;
  logic [6:0] pins_q;
  wire logic [31:0] hrdata;
  wire logic hreadyout, irq, cen, cclr, fmt, dbg;
  wire logic [1:0] cmode;
  int total_checks = 0, miscompares = 0;
  localparam logic [31:0] ALM = 32'h8642_a9c5;
  rtcca_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .counter_source_clock(cclk),
    .clock_value(cval), .write_protect(wprot), .counter_enable(cen),
    .counter_clear(cclr), .counter_mode(cmode),
    .hour_format_select(fmt), .debug_control(dbg), .irq(irq));
  initial forever #5 hclk = ~hclk;
  initial begin
    #3;
    forever #7 cclk = ~cclk;
  end
  // sample mid-cycle so a registered output never races the edge
  task automatic w_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    rd_q = hrdata;
    pins_q = {irq, cen, cclr, cmode, fmt, dbg};
    @(posedge hclk);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    w_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    w_rdy();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0000_0000);
    v = rd_q;
  endtask
  task automatic poll(input logic [11:0] a, input logic [38:0] m, e);
    int n;
    n = 0;
    rd(a, q);
    while (({pins_q, q} & m) !== e && n < 200) begin
      n++;
      rd(a, q);
    end
    `CHK({pins_q, q} & m, e)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500_000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h000, q); `CHK(q, 32'h0000_0000)
    rd(12'h020, q); `CHK(q, 32'h0000_0000)
    rd(12'h040, q); `CHK(q, 32'h0000_0000)
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, 32'(i) << 2);
      poll(12'h000, 39'h0c_ffff_ffff, (39'(i) << 34) | (39'(i) << 2));
    end
    wr(12'h008, 32'h0000_0001);
    wr(12'h000, 32'h0000_00c8);
    poll(12'h000, 39'h7f_ffff_ffff, 39'h0b_0000_00c8);
    $display("modes done");
    wr(12'h020, ALM);
    poll(12'h004, 39'h4, 39'h0);
    rd(12'h020, q); `CHK(q, ALM)
    cval <= ALM ^ 32'h0400_0000;
    wr(12'h01c, 32'h0000_0005);
    wr(12'h010, 32'h0000_0001);
    wr(12'h000, 32'h0000_00ca);
    rd(12'h004, q); `CHK(q[1], 1'b1)
    rd(12'h000, q); `CHK(q, 32'h0000_00ca)
    poll(12'h004, 39'h20_0000_0002, 39'h20_0000_0000);
    $display("enable done");
    // year differs but depth 5 leaves it out
    poll(12'h00c, 39'h50_0000_0001, 39'h50_0000_0001);
    wr(12'h00c, 32'h0000_0000);
    rd(12'h00c, q); `CHK(q[0], 1'b1)
    cval <= ALM ^ 32'h0000_0001;
    poll(12'h00c, 39'h10_0000_0000, 39'h0);
    wr(12'h00c, 32'h0000_0001);
    poll(12'h00c, 39'h40_0000_0001, 39'h0);
    wr(12'h01c, 32'h0000_0006);
    poll(12'h004, 39'h7, 39'h0);
    cval <= ALM ^ 32'h0400_0000;
    repeat (8) rd(12'h00c, q);
    `CHK(q[0], 1'b0)
    rd(12'h018, q); `CHK(q, ALM ^ 32'h0400_0000)
    $display("alarm done");
    wprot <= 1'b1;
    wr(12'h020, 32'h0000_0001);
    rd(12'h020, q); `CHK(q, ALM)
    wprot <= 1'b0;
    wr(12'h000, 32'h0000_000a);
    rd(12'h000, q); `CHK(q, 32'h0000_00ca)
    wr(12'h010, 32'h0000_0000);
    wr(12'h000, 32'h0000_0007);
    rd(12'h000, q); `CHK(q[0], 1'b1)
    poll(12'h000, 39'h7f_ffff_ffff, 39'h01_0000_0000);
    rd(12'h020, q); `CHK(q, 32'h0000_0000)
    rd(12'h008, q); `CHK(q[0], 1'b1)
    $display("soft reset done");
    tally_and_finish();
  end
endmodule // tb_rtcca_top
`default_nettype wire
